//--- iuv_fault_resp.sv
// Input undervoltage fault response sequencer with its action register.
// Assumes register traffic, time unit ticks, clears and the on command come from logic on clk,
// and the undervoltage comparator level is asynchronous.
`timescale 1ns/10ps
module iuv_fault_resp
    import iuv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    input wire logic uv_fault_async,
    input wire logic time_unit_tick,
    input wire logic fault_clear,
    input wire logic output_cmd_on,
    input wire logic other_fault_off,
    output logic out_enable_ff,
    output logic fault_latched_ff,
    output logic retrying_ff,
    output logic [2:0] attempts_ff
);
    iuv_cfg_type cfg_ff;
    iuv_cfg_type nxt_cfg;
    logic [7:0] nxt_rdata;
    iuv_state_type state_ff;
    iuv_state_type nxt_state;
    logic nxt_out_enable;
    logic nxt_fault_latched;
    logic nxt_retrying;
    logic [2:0] nxt_attempts;
    logic [2:0] attempts_inc;
    logic fault_s;
    logic timer_start;
    logic timer_clr;
    logic timer_expired;
    logic go_idle;
    logic cfg_hit;
    logic [IUV_CNT_W-1:0] tick_seen_ff;
    logic [IUV_CNT_W-1:0] nxt_tick_seen;

    // The comparator level crosses into clk before any logic reads it.
    iuv_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(uv_fault_async),
        .dout(fault_s)
    );

    // Shared timer for the run-on delay and the spacing of restart attempts.
    iuv_timer u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .start(timer_start),
        .clr(timer_clr),
        .tick(time_unit_tick),
        .sel(cfg_ff.delay),
        .expired(timer_expired)
    );

    // Register decode: a write to the action code replaces it; other codes read zero.
    assign cfg_hit = (reg_addr == IUV_REG_ADDR);

    always_comb begin
        nxt_cfg = cfg_ff;
        if (reg_wr_en && cfg_hit) begin
            nxt_cfg = iuv_cfg_type'(reg_wdata);
        end
        nxt_rdata = cfg_hit ? 8'(cfg_ff) : 8'h00;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= iuv_cfg_type'(IUV_REG_RST);
            reg_rdata_ff <= 8'h00;
        end else begin
            cfg_ff <= nxt_cfg;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // A clear or an off command ends any sequence and starts the next one afresh.
    assign go_idle = fault_clear || !output_cmd_on;
    assign timer_clr = go_idle;
    // Attempt counter saturates so continuous retry never wraps.
    assign attempts_inc = (attempts_ff == 3'h7) ? attempts_ff : attempts_ff + 3'h1;

    // Response sequence: decide state, output enable, status and attempt count.
    always_comb begin
        nxt_state = state_ff;
        nxt_fault_latched = fault_latched_ff;
        nxt_retrying = retrying_ff;
        nxt_attempts = attempts_ff;
        timer_start = 1'b0;
        if (go_idle) begin
            nxt_state = ST_RUN;
            nxt_fault_latched = 1'b0;
            nxt_retrying = 1'b0;
            nxt_attempts = 3'h0;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (fault_s) begin
                        case (cfg_ff.action)
                            IUV_ACT_IGNORE: begin
                                nxt_state = ST_RUN;
                            end
                            IUV_ACT_DLY_OP: begin
                                nxt_state = ST_DLY_OP;
                                nxt_fault_latched = 1'b1;
                                timer_start = 1'b1;
                            end
                            IUV_ACT_DISABLE: begin
                                nxt_fault_latched = 1'b1;
                                if (cfg_ff.retries == IUV_RTY_NONE) begin
                                    nxt_state = ST_LATCH;
                                end else begin
                                    nxt_state = ST_OFF_WAIT;
                                    nxt_retrying = 1'b1;
                                    timer_start = 1'b1;
                                end
                            end
                            IUV_ACT_LATCH: begin
                                nxt_state = ST_LATCH;
                                nxt_fault_latched = 1'b1;
                            end
                            default: begin
                                nxt_state = ST_LATCH;
                                nxt_fault_latched = 1'b1;
                            end
                        endcase
                    end
                end
                ST_DLY_OP: begin
                    if (other_fault_off) begin
                        nxt_state = ST_LATCH;
                    end else if (!fault_s) begin
                        nxt_state = ST_RUN;
                    end else if (timer_expired) begin
                        if (cfg_ff.retries == IUV_RTY_NONE) begin
                            nxt_state = ST_LATCH;
                        end else begin
                            nxt_state = ST_OFF_WAIT;
                            nxt_retrying = 1'b1;
                            timer_start = 1'b1;
                        end
                    end
                end
                ST_OFF_WAIT: begin
                    if (other_fault_off) begin
                        nxt_state = ST_LATCH;
                        nxt_retrying = 1'b0;
                    end else if (timer_expired) begin
                        // Each expiry is the start of one restart attempt.
                        if (!fault_s) begin
                            nxt_state = ST_RUN;
                            nxt_retrying = 1'b0;
                            nxt_attempts = 3'h0;
                        end else if (cfg_ff.retries != IUV_RTY_FOREVER && attempts_inc >= cfg_ff.retries) begin
                            nxt_state = ST_LATCH;
                            nxt_retrying = 1'b0;
                            nxt_attempts = attempts_inc;
                        end else begin
                            nxt_attempts = attempts_inc;
                            timer_start = 1'b1;
                        end
                    end
                end
                ST_LATCH: begin
                    nxt_state = ST_LATCH;
                end
                default: begin
                    nxt_state = ST_LATCH;
                end
            endcase
        end
        nxt_out_enable = output_cmd_on && (nxt_state == ST_RUN || nxt_state == ST_DLY_OP);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_RUN;
            out_enable_ff <= 1'b0;
            fault_latched_ff <= 1'b0;
            retrying_ff <= 1'b0;
            attempts_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            out_enable_ff <= nxt_out_enable;
            fault_latched_ff <= nxt_fault_latched;
            retrying_ff <= nxt_retrying;
            attempts_ff <= nxt_attempts;
        end
    end

    // Checker helper: ticks seen since the timer was last started.
    always_comb begin
        nxt_tick_seen = tick_seen_ff;
        if (timer_start || timer_clr) begin
            nxt_tick_seen = '0;
        end else if (time_unit_tick) begin
            nxt_tick_seen = tick_seen_ff + IUV_CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_seen_ff <= '0;
        end else begin
            tick_seen_ff <= nxt_tick_seen;
        end
    end

    a_ignore_keeps_on: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_RUN && cfg_ff.action == IUV_ACT_IGNORE && fault_s && !go_idle && !reg_wr_en)
        |=> out_enable_ff && state_ff == ST_RUN)
        else $error("Ignored fault disturbed the output.");

    a_delay_op_on: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_DLY_OP) |-> out_enable_ff)
        else $error("Output off while running on after fault.");

    a_disable_at_once: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_RUN && cfg_ff.action == IUV_ACT_DISABLE && fault_s && !go_idle && !reg_wr_en)
        |=> !out_enable_ff ##1 !out_enable_ff)
        else $error("Output not disabled on fault.");

    a_latch_holds_off: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_LATCH && !go_idle) |=> state_ff == ST_LATCH && !out_enable_ff)
        else $error("Latched fault released without clear.");

    a_no_retry_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_RUN && cfg_ff.action == IUV_ACT_DISABLE && cfg_ff.retries == IUV_RTY_NONE
         && fault_s && !go_idle && !reg_wr_en) |=> state_ff == ST_LATCH)
        else $error("Restart attempted with retry disabled.");

    a_attempt_limit: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT && cfg_ff.retries != IUV_RTY_FOREVER) |-> attempts_ff < cfg_ff.retries)
        else $error("Too many restart attempts.");

    a_spacing_count: assert property (@(posedge clk) disable iff (!arst_n)
        timer_expired |-> tick_seen_ff == (IUV_CNT_ONE << cfg_ff.delay))
        else $error("Delay not equal to two-power count of units.");

    a_retry_forever: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT && cfg_ff.retries == IUV_RTY_FOREVER && timer_expired && fault_s
         && !other_fault_off && !go_idle && !reg_wr_en) |=> state_ff == ST_OFF_WAIT && !out_enable_ff)
        else $error("Continuous retry stopped.");

    a_clear_restarts: assert property (@(posedge clk) disable iff (!arst_n)
        go_idle |=> attempts_ff == 3'h0 && state_ff == ST_RUN && !fault_latched_ff && !retrying_ff)
        else $error("Clear did not reset the sequence.");

    // Register and status checks.
    a_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_wr_en && cfg_hit)
        |=> cfg_ff == iuv_cfg_type'($past(reg_wdata)))
        else $error("Register write did not land.");

    a_ignore_no_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_RUN && cfg_ff.action == IUV_ACT_IGNORE && !fault_latched_ff && !reg_wr_en)
        |=> !fault_latched_ff)
        else $error("Ignored fault set the latched status.");

    a_off_cmd_dark: assert property (@(posedge clk) disable iff (!arst_n)
        !output_cmd_on
        |=> !out_enable_ff)
        else $error("Output on while commanded off.");

    a_latch_action: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_RUN && cfg_ff.action == IUV_ACT_LATCH && fault_s && !go_idle && !reg_wr_en)
        |=> state_ff == ST_LATCH && fault_latched_ff && !out_enable_ff)
        else $error("Latching action did not latch off.");

    // Sequencing checks.
    a_off_wait_dark: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT)
        |-> !out_enable_ff && retrying_ff && fault_latched_ff)
        else $error("Output on or status wrong between restart attempts.");

    a_latch_steady: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_LATCH)
        |-> !out_enable_ff && !retrying_ff && fault_latched_ff)
        else $error("Latched state shows wrong status.");

    a_delay_expiry: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_DLY_OP && timer_expired && fault_s && cfg_ff.retries != IUV_RTY_NONE
         && !other_fault_off && !go_idle && !reg_wr_en)
        |=> state_ff == ST_OFF_WAIT && !out_enable_ff)
        else $error("Persisting fault did not stop the output after the delay.");

    a_limit_latches: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT && timer_expired && fault_s && cfg_ff.retries != IUV_RTY_FOREVER
         && attempts_ff + 3'h1 == cfg_ff.retries && !other_fault_off && !go_idle && !reg_wr_en)
        |=> state_ff == ST_LATCH && attempts_ff == cfg_ff.retries)
        else $error("Last failed attempt did not latch off.");

    a_restart_ok: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT && timer_expired && !fault_s && !other_fault_off && !go_idle)
        |=> state_ff == ST_RUN && out_enable_ff && !retrying_ff && attempts_ff == 3'h0)
        else $error("Successful restart did not enable the output.");

    a_retry_count_step: assert property (@(posedge clk) disable iff (!arst_n)
        (state_ff == ST_OFF_WAIT && cfg_ff.retries == IUV_RTY_FOREVER && timer_expired && fault_s
         && attempts_ff != 3'h7 && !other_fault_off && !go_idle && !reg_wr_en)
        |=> attempts_ff == $past(attempts_ff) + 3'h1)
        else $error("Failed attempt not counted.");

    a_other_fault_stops: assert property (@(posedge clk) disable iff (!arst_n)
        ((state_ff == ST_OFF_WAIT || state_ff == ST_DLY_OP) && other_fault_off && !go_idle)
        |=> state_ff == ST_LATCH && !out_enable_ff && !retrying_ff)
        else $error("Another fault did not stop the sequence.");
endmodule

//--- iuv_pkg.sv
// Constants, field layout and carrier types of the input undervoltage fault response.
// Assumes a PMBus command decoder outside that presents byte writes and reads by command code.
//
// What this block does
// - Action 00 ignores fault, output stays on.
// - Action 01 runs for delay, then retries.
// - Action 10 disables output at once, then retries.
// - Action 11 latches off until fault cleared.
// - Retry 000 means no restart, stay off.
// - Retry 1 to 6 attempts, then latch off.
// - Attempts start one delay apart.
// - Retry 111 retries until off or other fault.
// - Delay field gives two-power count of units.
// - Delay count uses external time unit ticks.
// - Fault comes from external limit comparator.
package iuv_pkg;

    // Command code of the fault action register.
    localparam logic [7:0] IUV_REG_ADDR = 8'h5A;
    // Reset value of the fault action register: disable until cleared.
    localparam logic [7:0] IUV_REG_RST = 8'hC0;
    // Field positions inside the register.
    localparam int IUV_ACT_LSB = 6;
    localparam int IUV_RTY_LSB = 3;
    localparam int IUV_DLY_LSB = 0;
    // Action codes.
    localparam logic [1:0] IUV_ACT_IGNORE = 2'h0;
    localparam logic [1:0] IUV_ACT_DLY_OP = 2'h1;
    localparam logic [1:0] IUV_ACT_DISABLE = 2'h2;
    localparam logic [1:0] IUV_ACT_LATCH = 2'h3;
    // Retry codes.
    localparam logic [2:0] IUV_RTY_NONE = 3'h0;
    localparam logic [2:0] IUV_RTY_FOREVER = 3'h7;
    // Width of the time unit counter, enough for a count of 128.
    localparam int IUV_CNT_W = 9;
    localparam logic [IUV_CNT_W-1:0] IUV_CNT_ONE = 9'h001;

    // Fields of the fault action register.
    typedef struct packed {
        logic [1:0] action;
        logic [2:0] retries;
        logic [2:0] delay;
    } iuv_cfg_type;

    // Response sequence states.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DLY_OP,
        ST_OFF_WAIT,
        ST_LATCH
    } iuv_state_type;

endpackage

//--- iuv_sync.sv
// Two flip-flop synchroniser for the undervoltage comparator level.
// Assumes the comparator output is asynchronous to clk.
`timescale 1ns/10ps
module iuv_sync
    import iuv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;

    // Only the second stage is visible to the rest of the block.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

//--- iuv_timer.sv
// Delay timer that counts time unit ticks up to two to the power of the delay field.
// Assumes tick is a one-cycle pulse per time unit, made by logic on clk.
`timescale 1ns/10ps
module iuv_timer
    import iuv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic clr,
    input wire logic tick,
    input wire logic [2:0] sel,
    output logic expired
);
    logic [IUV_CNT_W-1:0] cnt_ff;
    logic [IUV_CNT_W-1:0] nxt_cnt;
    logic run_ff;
    logic nxt_run;
    logic exp_ff;
    logic nxt_exp;
    logic [IUV_CNT_W-1:0] target;

    // The target is a power of two count of units.
    assign target = IUV_CNT_ONE << sel;

    // Count ticks while armed and flag expiry for one cycle.
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        nxt_exp = 1'b0;
        if (clr) begin
            nxt_cnt = '0;
            nxt_run = 1'b0;
        end else if (start) begin
            nxt_cnt = '0;
            nxt_run = 1'b1;
        end else if (run_ff && tick) begin
            if (cnt_ff + IUV_CNT_ONE == target) begin
                nxt_exp = 1'b1;
                nxt_run = 1'b0;
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + IUV_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
            exp_ff <= nxt_exp;
        end
    end

    assign expired = exp_ff;
endmodule

//--- iuv_host_model.sv
// Host-side model of the controller that programs the fault action and issues clears.
// Assumes the design takes every request on the rising clk edge and gives no acknowledge.
`timescale 1ns/10ps
module iuv_host_model
    import iuv_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata_ff,
    output logic reg_wr_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic fault_clear,
    output logic output_cmd_on,
    output logic other_fault_off
);
    // Idle levels from time zero, with the output commanded on.
    initial begin
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fault_clear = 1'b0;
        output_cmd_on = 1'b1;
        other_fault_off = 1'b0;
    end

    // One byte write; the released data lines show the inverse so stale data cannot pass.
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~data;
    endtask

    // One byte read; the answer is registered on the same edge that takes the code.
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        @(posedge clk);
        #1;
        data = reg_rdata_ff;
    endtask

    // One-cycle clear of the fault.
    task automatic clear_faults();
        @(posedge clk);
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
    endtask

    // Commands the output off, then back on.
    task automatic cycle_on_off();
        @(posedge clk);
        output_cmd_on <= 1'b0;
        repeat (3) @(posedge clk);
        output_cmd_on <= 1'b1;
    endtask

    // Reports that another fault shut the unit down, or that it has gone.
    task automatic set_other_fault(input logic level);
        @(posedge clk);
        other_fault_off <= level;
    endtask
endmodule

//--- tb_iuv_fault_resp.sv
// Self-checking bench for the undervoltage fault response, with a host model and tick source.
// Assumes the design files and the package are compiled first.
`timescale 1ns/10ps
module tb_iuv_fault_resp
    import iuv_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic uv_fault_async = 1'b0;
    logic time_unit_tick = 1'b0;
    logic reg_wr_en, fault_clear, output_cmd_on, other_fault_off;
    logic out_enable_ff, fault_latched_ff, retrying_ff;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, rd;
    logic [2:0] attempts_ff;
    logic [2:0] last_att = 3'h0;
    int miscompares = 0;
    int samples_checked = 0;
    int tick_gap = 5;
    int tick_cnt = 0;
    int ticks_since = 0;
    int cur_dly = 0;
    int i, n;
    iuv_cfg_type cfg;

    iuv_fault_resp u_iuv_fault_resp (.clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .uv_fault_async(uv_fault_async),
        .time_unit_tick(time_unit_tick), .fault_clear(fault_clear), .output_cmd_on(output_cmd_on),
        .other_fault_off(other_fault_off), .out_enable_ff(out_enable_ff), .fault_latched_ff(fault_latched_ff),
        .retrying_ff(retrying_ff), .attempts_ff(attempts_ff));
    iuv_host_model u_iuv_host_model (.clk(clk), .reg_rdata_ff(reg_rdata_ff), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .fault_clear(fault_clear), .output_cmd_on(output_cmd_on),
        .other_fault_off(other_fault_off));

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    // Time unit tick, a one-cycle pulse every tick_gap cycles.
    always @(posedge clk) begin
        tick_cnt <= (tick_cnt + 1) % tick_gap;
        time_unit_tick <= (tick_cnt == 0);
    end

    // Counts time units between successive failed restarts and compares with the delay field.
    always @(posedge clk) begin
        if (attempts_ff !== last_att) begin
            // A clear after saturation wraps the three-bit sum to zero and is no attempt.
            if (last_att != 3'h0 && last_att != 3'h7 && attempts_ff === last_att + 3'h1) begin
                check("spacing", 16'(ticks_since), 16'(1 << cur_dly));
            end
            ticks_since = 0;
        end else if (time_unit_tick === 1'b1) begin
            ticks_since = ticks_since + 1;
        end
        last_att = attempts_ff;
    end

    // Compares one value with its expectation and counts the outcome.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Reference count of failed restarts once the sequence has latched off.
    function automatic int exp_att(input logic [1:0] act, input logic [2:0] rty);
        return (act == 2'h1 || act == 2'h2) && rty != 3'h7 ? int'(rty) : 0;
    endfunction

    // Waits, bounded, for a given output enable and retrying state.
    task automatic wait_until(input logic en, input logic rty);
        for (n = 0; n < 8000; n++) begin
            @(posedge clk);
            #1;
            if (out_enable_ff === en && retrying_ff === rty) break;
        end
        if (n == 8000) begin
            miscompares++;
            $display("mismatch wait expected %0h seen timeout", {en, rty});
            conclude();
        end
    endtask

    // Programs the action register, raises the fault and checks the first reaction.
    task automatic start_fault(input logic [1:0] act, input logic [2:0] rty, input logic [2:0] dly);
        cfg.action = act;
        cfg.retries = rty;
        cfg.delay = dly;
        cur_dly = int'(dly);
        u_iuv_host_model.write_byte(IUV_REG_ADDR, cfg);
        u_iuv_host_model.read_byte(IUV_REG_ADDR, rd);
        check("config", rd, cfg);
        @(posedge clk);
        uv_fault_async <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check("on after detect", out_enable_ff, act < 2'h2);
    endtask

    // Removes the fault, clears by pulse or by off then on, and checks a fresh start.
    task automatic release_fault(input logic by_onoff);
        @(posedge clk);
        uv_fault_async <= 1'b0;
        repeat (4) @(posedge clk);
        if (by_onoff) u_iuv_host_model.cycle_on_off();
        else u_iuv_host_model.clear_faults();
        repeat (3) @(posedge clk);
        #1;
        check("after clear", {out_enable_ff, fault_latched_ff, retrying_ff, attempts_ff}, 16'h20);
    endtask

    // One full fault response with a persisting fault.
    task automatic run_case(input logic [1:0] act, input logic [2:0] rty, input logic [2:0] dly);
        start_fault(act, rty, dly);
        if (act == 2'h0 || act == 2'h3) begin
            repeat (300) @(posedge clk);
            #1;
            check("hold state", {out_enable_ff, fault_latched_ff, retrying_ff, attempts_ff},
                act == 2'h0 ? 16'h20 : 16'h10);
        end else begin
            wait_until(1'b0, 1'b0);
            check("attempts", attempts_ff, 16'(exp_att(act, rty)));
        end
        release_fault(1'b0);
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'h164f8342));
        tick_gap = 4 + $urandom % 4;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        u_iuv_host_model.read_byte(IUV_REG_ADDR, rd);
        check("reset value", rd, IUV_REG_RST);
        u_iuv_host_model.write_byte(8'h5B, 8'h00);
        u_iuv_host_model.read_byte(8'h5B, rd);
        check("unmapped read", rd, 8'h00);
        u_iuv_host_model.read_byte(IUV_REG_ADDR, rd);
        check("unmapped write", rd, IUV_REG_RST);
        for (i = 0; i < 12; i++) begin
            run_case(2'(i), 3'(1 + i % 6), 3'(2 + $urandom % 2));
        end
        run_case(2'h2, 3'h0, 3'h0);
        run_case(2'h1, 3'h0, 3'h2);
        run_case(2'h2, 3'h2, 3'h7);
        start_fault(2'h2, 3'h7, 3'h0);
        for (n = 0; n < 2000 && attempts_ff !== 3'h7; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 2000) begin
            miscompares++;
            $display("mismatch retry wait expected 7 seen timeout");
            conclude();
        end
        repeat (40) @(posedge clk);
        #1;
        check("retry forever", {retrying_ff, attempts_ff}, 16'hF);
        u_iuv_host_model.set_other_fault(1'b1);
        repeat (3) @(posedge clk);
        #1;
        check("other fault stop", {out_enable_ff, retrying_ff}, 16'h0);
        u_iuv_host_model.set_other_fault(1'b0);
        release_fault(1'b1);
        start_fault(2'h2, 3'h3, 3'h2);
        @(posedge clk);
        uv_fault_async <= 1'b0;
        wait_until(1'b1, 1'b0);
        check("restart ok", attempts_ff, 16'h0);
        release_fault(1'b0);
        // A reset in mid-run clears a latched fault and restores the register.
        start_fault(2'h3, 3'h5, 3'h1);
        @(posedge clk);
        arst_n <= 1'b0;
        uv_fault_async <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("in reset", {out_enable_ff, fault_latched_ff, retrying_ff, attempts_ff, reg_rdata_ff}, 16'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        u_iuv_host_model.read_byte(IUV_REG_ADDR, rd);
        check("reset config", rd, IUV_REG_RST);
        check("reset status", {out_enable_ff, fault_latched_ff, retrying_ff, attempts_ff}, 16'h20);
        conclude();
    end
endmodule
